// File: design/asbw_host.sv
// Host controller that runs timed read and write cycles on a bit-wide async sram
`timescale 1ns/1ps
// Behaviour
// RL1: The memory writes only while select and strobe are both low, so the host keeps both low for the whole write.
// RL2: The host lowers both select and strobe to start a write and ends it by raising them together.
// RL3: Write data and address are held against the rising edge that ends the write.
// RL4: Select and strobe rise together at write end, so the memory output stays floating.
// RL5: In a read the address is valid no later than select falling.
// RL6: The strobe stays high through every read.
// RL7: Read data is sampled only after the address access time has passed.
// RL8: The memory keeps old data for a short hold after an address change.
// RL9: The address is stable for the address setup time before write end.
// RL10: The address may change at the write-ending edge, hold being zero.
// RL11: The address may appear at the write-starting edge, setup being zero.
// RL12: Input data is valid for the data setup time before write end.
// RL13: A write lasts at least the strobe float delay plus the data setup time.
// RL14: Select high floats the memory, select low with strobe high reads, both low writes.
module asbw_host #(
  parameter int ADDR_WIDTH   = asbw_pkg::ADDR_WIDTH,
  parameter int READ_CYCLES  = asbw_pkg::READ_CYCLES,
  parameter int WRITE_CYCLES = asbw_pkg::WRITE_CYCLES
) (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  resetn,
  // User request
  input  wire logic                  requestValid,
  input  wire logic                  requestWrite,
  input  wire logic [ADDR_WIDTH-1:0] requestAddress,
  input  wire logic                  requestData,
  output logic                       requestReady,
  // User answer
  output logic                       readValid,
  output logic                       readData,
  // Memory pins
  output logic [ADDR_WIDTH-1:0]      memAddress,
  output logic                       chipSelectN,
  output logic                       writeStrobeN,
  output logic                       dataInput,
  input  wire logic                  dataOutput
);

  localparam int CW = asbw_pkg::COUNT_WIDTH;

  asbw_pkg::asbw_state_t state;
  asbw_pkg::asbw_state_t next_state;
  logic                  phaseDone;
  logic                  timerLoad;
  logic [CW-1:0]         timerValue;
  logic                  startAccess;

  // ==========================================================================
  // Phase timer
  asbw_timer #(.WIDTH(CW)) phaseTimer (
    .clock     (clock),
    .resetn    (resetn),
    .load      (timerLoad),
    .loadValue (timerValue),
    .expired   (phaseDone)
  );

  // ==========================================================================
  // Decoding of the next state and timer load
  assign startAccess = (state == asbw_pkg::ST_IDLE) && requestValid && requestReady;
  assign timerLoad   = startAccess;
  assign timerValue  = requestWrite ? CW'(WRITE_CYCLES) : CW'(READ_CYCLES); // [RL7] [RL13]

  always_comb begin
    next_state = state;
    case (state)
      asbw_pkg::ST_IDLE: begin
        if (startAccess) begin
          next_state = requestWrite ? asbw_pkg::ST_WRITE : asbw_pkg::ST_READ;
        end
      end
      asbw_pkg::ST_READ: begin
        if (phaseDone) begin
          next_state = asbw_pkg::ST_IDLE;
        end
      end
      asbw_pkg::ST_WRITE: begin
        if (phaseDone) begin
          next_state = asbw_pkg::ST_IDLE;
        end
      end
      default: next_state = asbw_pkg::ST_IDLE;
    endcase
  end

  // ==========================================================================
  // State and handshake
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state        <= asbw_pkg::ST_IDLE;
      requestReady <= 1'b0;
    end else begin
      state        <= next_state;
      requestReady <= (next_state == asbw_pkg::ST_IDLE) && !startAccess;
    end
  end

  // ==========================================================================
  // Memory pins: address and data land with the select edge
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      memAddress   <= '0;
      dataInput    <= 1'b0;
      chipSelectN  <= 1'b1;                                         // [RL14]
      writeStrobeN <= 1'b1;
    end else begin
      if (startAccess) begin
        memAddress <= requestAddress;                               // [RL5] [RL11]
        dataInput  <= requestData;                                  // [RL12]
      end
      // Address and data stay put through the closing edge
      chipSelectN  <= !(next_state != asbw_pkg::ST_IDLE);           // [RL3] [RL9] [RL10]
      writeStrobeN <= !(next_state == asbw_pkg::ST_WRITE);          // [RL1] [RL2] [RL4] [RL6]
    end
  end

  // ==========================================================================
  // Read capture at the end of the access time
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      readValid <= 1'b0;
      readData  <= 1'b0;
    end else begin
      readValid <= (state == asbw_pkg::ST_READ) && phaseDone;
      if ((state == asbw_pkg::ST_READ) && phaseDone) begin
        readData <= dataOutput;                                     // [RL7] [RL8]
      end
    end
  end

endmodule : asbw_host

// File: design/asbw_pkg.sv
// Package of types and timing constants for the bit-wide sram host controller
package asbw_pkg;

  // ==========================================================================
  // Geometry
  localparam int ADDR_WIDTH = 18;
  localparam int CLOCK_PERIOD_PS = 5000;

  // ==========================================================================
  // Memory timing in picoseconds, fastest speed grade
  localparam int ADDRESS_ACCESS_TIME_PS        = 12000;
  localparam int OUTPUT_HOLD_AFTER_ADDRESS_PS  = 3000;
  localparam int ADDRESS_SETUP_TO_WRITE_END_PS = 9000;
  localparam int ADDRESS_HOLD_AFTER_WRITE_PS   = 0;
  localparam int ADDRESS_SETUP_TO_WRITE_START_PS = 0;
  localparam int INPUT_SETUP_TO_WRITE_END_PS   = 8000;
  localparam int STROBE_LOW_TO_FLOAT_PS        = 7000;

  // ==========================================================================
  // Cycle counts: least times round up, at least one cycle
  function automatic int cyclesUp(input int ps);
    int c;
    c = (ps + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : cyclesUp

  localparam int READ_CYCLES  = cyclesUp(ADDRESS_ACCESS_TIME_PS);
  localparam int WRITE_SETUP  = (ADDRESS_SETUP_TO_WRITE_END_PS > INPUT_SETUP_TO_WRITE_END_PS)
                              ? ADDRESS_SETUP_TO_WRITE_END_PS : INPUT_SETUP_TO_WRITE_END_PS;
  localparam int WRITE_TOTAL  = (WRITE_SETUP > STROBE_LOW_TO_FLOAT_PS + INPUT_SETUP_TO_WRITE_END_PS)
                              ? WRITE_SETUP : STROBE_LOW_TO_FLOAT_PS + INPUT_SETUP_TO_WRITE_END_PS;
  localparam int WRITE_CYCLES = cyclesUp(WRITE_TOTAL);
  localparam int COUNT_WIDTH  = 4;

  // ==========================================================================
  // Pin bundle toward the memory
  typedef struct packed {
    logic [ADDR_WIDTH-1:0] address;
    logic                  chipSelectN;
    logic                  writeStrobeN;
    logic                  dataInput;
  } asbw_pins_t;

  // Controller states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_READ  = 3'b010,
    ST_WRITE = 3'b100
  } asbw_state_t;

endpackage : asbw_pkg

// File: design/asbw_timer.sv
// Down counter that marks the end of a timed access phase
`timescale 1ns/1ps
module asbw_timer #(
  parameter int WIDTH = asbw_pkg::COUNT_WIDTH
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             resetn,
  // Control
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] loadValue,
  // Status
  output logic                  expired
);

  // Terminal count, sized to the counter so no compare mixes widths
  localparam logic [WIDTH-1:0] COUNT_ONE = WIDTH'(1);

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;

  // ==========================================================================
  // Count toward one, expire the cycle after reaching it
  assign next_count = load ? loadValue : ((count > COUNT_ONE) ? count - COUNT_ONE : count);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count   <= '0;
      expired <= 1'b0;
    end else begin
      count   <= next_count;
      expired <= !load && (count == COUNT_ONE) && (next_count == count);
    end
  end

endmodule : asbw_timer

// File: test/asbw_host_sva.sv
// Checker of the memory pin sequencing of the host controller
`timescale 1ns/1ps
module asbw_host_sva #(
  parameter int ADDR_WIDTH = asbw_pkg::ADDR_WIDTH
) (
  // Clock and reset
  input wire logic                  clock,
  input wire logic                  resetn,
  // Observed ports
  input wire logic                  requestReady,
  input wire logic                  readValid,
  input wire logic [ADDR_WIDTH-1:0] memAddress,
  input wire logic                  chipSelectN,
  input wire logic                  writeStrobeN,
  input wire logic                  dataInput
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // ==========================================================================
  // Access starts
  sequence s_wr_start; $fell(writeStrobeN); endsequence
  sequence s_rd_start; $fell(chipSelectN) && writeStrobeN; endsequence
  // Pin relations
  property p_wr_both; s_wr_start |-> $fell(chipSelectN); endproperty
  property p_wr_end; $rose(writeStrobeN) |-> $rose(chipSelectN); endproperty
  property p_rd_strobe; s_rd_start |-> writeStrobeN [*3]; endproperty
  property p_addr_hold; !chipSelectN && $past(!chipSelectN) |-> $stable(memAddress); endproperty
  property p_data_hold; !writeStrobeN && $past(!writeStrobeN) |-> $stable(dataInput); endproperty
  property p_wr_len; s_wr_start |-> !writeStrobeN [*3]; endproperty
  property p_rd_len; s_rd_start |-> !chipSelectN [*3] ##[1:4] readValid; endproperty
  property p_ready_idle; requestReady |-> chipSelectN && writeStrobeN; endproperty
  a_wr_both: assert property (p_wr_both) else $error("strobe fell alone");
  a_wr_end: assert property (p_wr_end) else $error("write end not joint");
  a_rd_strobe: assert property (p_rd_strobe) else $error("strobe low in read");
  a_addr_hold: assert property (p_addr_hold) else $error("address moved");
  a_data_hold: assert property (p_data_hold) else $error("write data moved");
  a_wr_len: assert property (p_wr_len) else $error("write too short");
  a_rd_len: assert property (p_rd_len) else $error("read timing wrong");
  a_ready_idle: assert property (p_ready_idle) else $error("ready while busy");
endmodule : asbw_host_sva

bind asbw_host asbw_host_sva #(.ADDR_WIDTH(ADDR_WIDTH)) u_sva (.clock(clock), .resetn(resetn),
  .requestReady(requestReady), .readValid(readValid), .memAddress(memAddress),
  .chipSelectN(chipSelectN), .writeStrobeN(writeStrobeN), .dataInput(dataInput));

// File: test/asbw_sram_model.sv
// Behavioural bit-wide async sram answering the host controller
`timescale 1ns/1ps
module asbw_sram_model #(
  parameter int ACCESS_NS = 12,
  parameter int HOLD_NS   = 3
) (
  // Memory pins
  input wire logic [asbw_pkg::ADDR_WIDTH-1:0] memAddress,
  input wire logic                            chipSelectN,
  input wire logic                            writeStrobeN,
  input wire logic                            dataInput,
  output logic                                dataOutput
);
  logic cells [0:(1<<asbw_pkg::ADDR_WIDTH)-1];
  initial dataOutput = 1'b0;
  // Store while select and strobe overlap low
  always @(memAddress, chipSelectN, writeStrobeN, dataInput) begin
    if (!chipSelectN && !writeStrobeN) begin
      cells[memAddress] = dataInput;
    end
  end
  // Old bit held briefly, then garbage unless a read settles
  always @(memAddress, chipSelectN, writeStrobeN) begin
    dataOutput <= #(HOLD_NS) ~dataOutput;
    if (!chipSelectN && writeStrobeN) begin
      dataOutput <= #(ACCESS_NS) cells[memAddress];
    end
  end
endmodule : asbw_sram_model

// File: test/asbw_host_tb.sv
// Testbench of the bit-wide sram host controller
`timescale 1ns/1ps
module asbw_host_tb;
  logic clock, resetn, requestValid, requestWrite, requestData, requestReady, readValid;
  logic readData, chipSelectN, writeStrobeN, dataInput, dataOutput;
  logic [17:0] requestAddress, memAddress;
  logic [17:0] addrs [4] = '{18'h00000, 18'h3ffff, 18'h00001, 18'h2aaaa};
  int nErrors = 0, compares = 0, cycles = 0;
  // Clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  asbw_host u_dut (.clock(clock), .resetn(resetn), .requestValid(requestValid),
    .requestWrite(requestWrite), .requestAddress(requestAddress), .requestData(requestData),
    .requestReady(requestReady), .readValid(readValid), .readData(readData),
    .memAddress(memAddress), .chipSelectN(chipSelectN), .writeStrobeN(writeStrobeN),
    .dataInput(dataInput), .dataOutput(dataOutput));
  asbw_sram_model u_mem (.memAddress(memAddress), .chipSelectN(chipSelectN),
    .writeStrobeN(writeStrobeN), .dataInput(dataInput), .dataOutput(dataOutput));
  // ==========================================================================
  // Helpers
  task automatic chk(input string what, input logic [31:0] expv, input logic [31:0] got);
    compares++;
    if (got !== expv) begin
      nErrors++;
      $display("mismatch %s expected %0h seen %0h", what, expv, got);
    end
  endtask : chk
  task automatic stop_test();
    if (nErrors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  // One request held until taken; pins checked, reads timed and answered
  task automatic access(input logic w, input logic [17:0] a, input logic d, output logic q);
    int n;
    n = 0;
    requestValid <= 1'b1;
    requestWrite <= w;
    requestAddress <= a;
    requestData <= d;
    do @(posedge clock); while (requestReady !== 1'b1 && n++ < 40);
    chk("requestReady", 1'b1, requestReady);
    requestValid <= 1'b0;
    @(posedge clock);
    chk("memAddress", a, memAddress);
    chk("chipSelectN", 1'b0, chipSelectN);
    chk("writeStrobeN", !w, writeStrobeN);
    if (w) chk("dataInput", d, dataInput);
    n = 1;
    if (!w) begin
      while (readValid !== 1'b1 && n < 40) begin
        @(posedge clock);
        n++;
      end
      chk("readLatency", asbw_pkg::READ_CYCLES + 2, n);
      q = readData;
      @(posedge clock);
      chk("readValid", 1'b0, readValid);
    end
  endtask : access
  // ==========================================================================
  // Scenarios
  task automatic t_reset_pins();
    chk("chipSelectN", 1'b1, chipSelectN);
    chk("writeStrobeN", 1'b1, writeStrobeN);
    chk("requestReady", 1'b0, requestReady);
    chk("readValid", 1'b0, readValid);
    chk("readData", 1'b0, readData);
    chk("memAddress", 18'h00000, memAddress);
    chk("dataInput", 1'b0, dataInput);
  endtask : t_reset_pins
  // Reset in the middle of a read, then the stored bit is read again
  task automatic t_mid_reset();
    logic q;
    requestValid <= 1'b1;
    requestWrite <= 1'b0;
    requestAddress <= addrs[2];
    do @(posedge clock); while (requestReady !== 1'b1);
    requestValid <= 1'b0;
    @(posedge clock);
    resetn <= 1'b0;
    @(posedge clock);
    t_reset_pins();
    resetn <= 1'b1;
    repeat (2) @(posedge clock);
    chk("requestReady", 1'b1, requestReady);
    access(1'b0, addrs[2], 1'b0, q);
    chk("readData", 1'b1, q);
  endtask : t_mid_reset
  task automatic t_write_read(input logic inv);
    logic q;
    foreach (addrs[i]) access(1'b1, addrs[i], i[0] ^ inv, q);
    foreach (addrs[i]) begin
      access(1'b0, addrs[i], 1'b0, q);
      chk("readData", i[0] ^ inv, q);
    end
    chk("chipSelectN", 1'b1, chipSelectN);
  endtask : t_write_read
  // Timeout
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      nErrors++;
      stop_test();
    end
  end
  // Main sequence
  initial begin
    {resetn, requestValid, requestWrite, requestData, requestAddress} <= '0;
    repeat (20) @(posedge clock);
    t_reset_pins();
    resetn <= 1'b1;
    @(posedge clock);
    t_write_read(1'b0);
    t_write_read(1'b1);
    t_mid_reset();
    stop_test();
  end
endmodule : asbw_host_tb
